// file: hw/gpio_pin_pkg.sv
/*
 * shared constants for the gpio pin input block: register byte offsets,
 * field positions, reset values and filter timing.
 * assumes a 32-bit ahb-lite register bus with 16 decoded address bits.
 */
package gpio_pin_pkg;
	// ************************************************************
	// register byte offsets
	// ************************************************************
	localparam logic [15:0] OFS_PIN_CFG    = 16'hA110;
	localparam logic [15:0] OFS_FUNC_SEL   = 16'hA120;
	localparam logic [15:0] OFS_IRQ_STATUS = 16'hA130;
	localparam logic [15:0] OFS_IRQ_MASK   = 16'hA134;
	localparam logic [15:0] OFS_CFG_VIEW   = 16'hA138;

	// ************************************************************
	// pin config fields (read and write views differ)
	// ************************************************************
	localparam int BIT_CHAN_B      = 7;
	localparam int BIT_CHAN_A      = 6;
	localparam int BIT_RISE        = 5; // flag on read, enable on write
	localparam int BIT_FALL        = 4;
	localparam int BIT_INBUF_EN    = 3;
	localparam int BIT_CHECK       = 2; // flag on read, enable on write
	localparam int BIT_FILTERED    = 1;
	localparam int BIT_RAW         = 0;
	localparam int FILTER_SEL_LSB  = 0;

	// status / mask layout
	localparam int IRQ_RISE        = 0;
	localparam int IRQ_FALL        = 1;
	localparam int IRQ_CHECK       = 2;
	localparam int IRQ_W           = 3;

	// ************************************************************
	// reset values and timing
	// ************************************************************
	localparam logic [7:0] PIN_CFG_RST  = 8'h00;
	localparam logic [7:0] FUNC_SEL_RST = 8'h00;
	localparam logic [2:0] IRQ_MASK_RST = 3'h0;
	localparam int CHECK_DELAY      = 3;   // system clocks from change to compare
	localparam int FILTER_CNT_W     = 7;
	localparam logic [6:0] FILT_SHORT  = 7'h04; // slow-osc periods
	localparam logic [6:0] FILT_MID    = 7'h10;
	localparam logic [6:0] FILT_LONG   = 7'h40;
	localparam logic [1:0] FILT_OFF    = 2'h0;

	// slow-osc periods required by a filter selection
	function automatic logic [6:0] filterPeriods(input logic [1:0] sel);
		unique case (sel)
			2'h1: filterPeriods = FILT_SHORT;
			2'h2: filterPeriods = FILT_MID;
			2'h3: filterPeriods = FILT_LONG;
			default: filterPeriods = 7'h00;
		endcase
	endfunction : filterPeriods
endpackage : gpio_pin_pkg

// file: hw/debounce_filter.sv
/*
 * de-bounce filter: passes a synchronised level once it has been stable
 * for the selected number of slow oscillator periods.
 * assumes tick is a one-cycle pulse per slow oscillator period.
 */
`timescale 1ns/1ps
module debounce_filter
	import gpio_pin_pkg::*;
(
	input  wire logic       clk,      // system clock
	input  wire logic       rst_n,    // sync reset, active low
	input  wire logic       level,    // synchronised pin level
	input  wire logic       tick,     // slow osc period pulse
	input  wire logic [1:0] sel,      // filter time select
	output logic            filtered  // de-bounced level
);
	logic [FILTER_CNT_W-1:0] stableCnt;

	// count stable periods; any return to the old level restarts it
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			stableCnt <= '0;
			filtered  <= 1'b0;
		end else if (sel == FILT_OFF) begin
			stableCnt <= '0;
			filtered  <= level;
		end else if (level == filtered) begin
			stableCnt <= '0;
		end else if (tick) begin
			if (stableCnt + 7'h01 >= filterPeriods(sel)) begin
				stableCnt <= '0;
				filtered  <= level;
			end else begin
				stableCnt <= stableCnt + 7'h01;
			end
		end
	end

	filter_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
		(sel != FILT_OFF && $past(sel) != FILT_OFF && !$past(tick) && rst_n && $past(rst_n))
		|-> $stable(filtered))
		else $error("filtered level moved without a slow tick");
endmodule : debounce_filter

// file: hw/output_check.sv
/*
 * output error check: when the driven value changes, compares it with the
 * pin level seen a fixed number of system clocks later.
 * assumes both inputs are synchronous to clk.
 */
`timescale 1ns/1ps
module output_check
	import gpio_pin_pkg::*;
(
	input  wire logic clk,      // system clock
	input  wire logic rst_n,    // sync reset, active low
	input  wire logic enable,   // detection enable
	input  wire logic driven,   // value driven onto the pin
	input  wire logic sampled,  // pin level from input buffer
	output logic      mismatch  // one-cycle error pulse
);
	logic                   lastDriven;
	logic [CHECK_DELAY-1:0] chgPipe;
	logic [CHECK_DELAY-1:0] expPipe;

	// carry each change and its value down a short delay line
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			lastDriven <= 1'b0;
			chgPipe    <= '0;
			expPipe    <= '0;
		end else begin
			lastDriven <= driven;
			chgPipe    <= {chgPipe[CHECK_DELAY-2:0], enable && (driven != lastDriven)};
			expPipe    <= {expPipe[CHECK_DELAY-2:0], driven};
		end
	end

	// compare only on changes, so a steady pin costs nothing
	assign mismatch = enable && chgPipe[CHECK_DELAY-1] && (sampled != expPipe[CHECK_DELAY-1]);

	check_delay_a: assert property (@(posedge clk) disable iff (!rst_n)
		mismatch |-> ($past(driven, 3) != sampled && $past(driven, 3) != $past(driven, 4)))
		else $error("mismatch not tied to change three cycles earlier");
endmodule : output_check

// file: hw/gpio_pin_input.sv
/*
 * per-pin input side of a general purpose port: input buffer gate,
 * synchroniser, de-bounce, edge flags, output error check, interrupt
 * status/mask and the port function select register, on ahb-lite.
 * assumes one system clock; slowOsc is the free-running slow oscillator
 * level and pinIn / pinOutValue are synchronous inputs.
 */
// Decided for this implementation: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
// Function
// - rising edge sets rise flag when channel enabled
// - writing zero rise enable clears rise flag
// - falling edge sets fall flag when channel enabled
// - writing zero fall enable clears fall flag
// - buffer disabled forces its output low
// - compare driven value with input three clocks later
// - compare on every output change, mismatch sets flag
// - error interrupt only with a channel enabled
// - writing zero check enable disables, clears flag
// - read-only de-bounced pin level bit
// - de-bounced level feeds interrupts and port data
// - read-only raw input buffer level bit
// - filter select: off, 4, 16, 64 periods
// - eight-bit function select register, reset zero
// - edge latches capture rising and falling transitions
// - eight-bit pin config register, reset zero
module gpio_pin_input
	import gpio_pin_pkg::*;
#(
	parameter int ADDR_W = 16
) (
	input  wire logic              clk,           // system clock, 40 MHz
	input  wire logic              rst_n,         // sync reset, active low
	input  wire logic              hsel,          // slave select
	input  wire logic [ADDR_W-1:0] haddr,         // byte address
	input  wire logic [1:0]        htrans,        // transfer type
	input  wire logic              hwrite,        // write not read
	input  wire logic [2:0]        hsize,         // transfer size
	input  wire logic [31:0]       hwdata,        // write data
	input  wire logic              hready,        // bus ready
	output logic                   hreadyout,     // slave ready
	output logic [31:0]            hrdata,        // read data
	output logic                   hresp,         // always okay
	input  wire logic              pinIn,         // pin level
	input  wire logic              pinOutValue,   // value driven to pin
	input  wire logic              slowOsc,       // slow oscillator level
	output logic                   filteredLevel, // level for port data
	output logic [7:0]             functionSelect,// alternate function
	output logic                   pinIrqA,       // pin interrupt channel a
	output logic                   pinIrqB,       // pin interrupt channel b
	output logic                   irq            // summary interrupt
);
	// ************************************************************
	// register state
	// ************************************************************
	logic              chanB;
	logic              chanA;
	logic              riseEn;
	logic              fallEn;
	logic              inBufEn;
	logic              checkEn;
	logic [1:0]        filterSel;
	logic              riseFlag;
	logic              fallFlag;
	logic              checkFlag;
	logic [IRQ_W-1:0]  irqStatus;
	logic [IRQ_W-1:0]  irqMask;

	// bus pipeline
	logic              wrPending;
	logic [ADDR_W-1:0] wrAddr;
	logic              accept;
	logic              cfgWrite;

	// input path
	logic              bufOut;
	logic              pinMeta;
	logic              pinSync;
	logic              oscMeta;
	logic              oscSync;
	logic              oscLast;
	logic              slowTick;
	logic              filtLast;
	logic              riseEvt;
	logic              fallEvt;
	logic              chanAny;
	logic              checkErr;
	logic [7:0]        pinCfgRead;

	// ************************************************************
	// ahb-lite slave
	// ************************************************************
	assign accept = hsel && htrans[1] && hready;
	// a read straight after a write waits one cycle so it sees new data
	assign hreadyout = !(wrPending && hsel && htrans[1] && !hwrite);
	assign hresp     = 1'b0;
	assign cfgWrite  = wrPending && (wrAddr == OFS_PIN_CFG);

	// capture the write address phase; data lands in the data phase
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			wrPending <= 1'b0;
			wrAddr    <= '0;
		end else begin
			wrPending <= accept && hwrite;
			if (accept && hwrite) begin
				wrAddr <= haddr;
			end
		end
	end

	// pin config readback with flags and live levels
	assign pinCfgRead = {chanB, chanA, riseFlag, fallFlag, inBufEn, checkFlag,
		filteredLevel, pinSync};

	// read data registered at the address phase; unmapped reads zero
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			hrdata <= 32'h0000_0000;
		end else if (accept && !hwrite) begin
			unique case (haddr)
				OFS_PIN_CFG:    hrdata <= {24'h000000, pinCfgRead};
				OFS_FUNC_SEL:   hrdata <= {24'h000000, functionSelect};
				OFS_IRQ_STATUS: hrdata <= {29'h00000000, irqStatus};
				OFS_IRQ_MASK:   hrdata <= {29'h00000000, irqMask};
				OFS_CFG_VIEW:   hrdata <= {24'h000000, chanB, chanA, riseEn, fallEn,
					inBufEn, checkEn, filterSel};
				default:        hrdata <= 32'h0000_0000;
			endcase
		end
	end

	// ************************************************************
	// configuration registers
	// ************************************************************
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			{chanB, chanA, riseEn, fallEn, inBufEn, checkEn, filterSel} <= PIN_CFG_RST;
		end else if (cfgWrite) begin
			chanB     <= hwdata[BIT_CHAN_B];
			chanA     <= hwdata[BIT_CHAN_A];
			riseEn    <= hwdata[BIT_RISE];
			fallEn    <= hwdata[BIT_FALL];
			inBufEn   <= hwdata[BIT_INBUF_EN];
			checkEn   <= hwdata[BIT_CHECK];
			filterSel <= hwdata[FILTER_SEL_LSB +: 2];
		end
	end

	// function select only steers the pin mux outside this block
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			functionSelect <= FUNC_SEL_RST;
		end else if (wrPending && wrAddr == OFS_FUNC_SEL) begin
			functionSelect <= hwdata[7:0];
		end
	end

	// interrupt mask
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			irqMask <= IRQ_MASK_RST;
		end else if (wrPending && wrAddr == OFS_IRQ_MASK) begin
			irqMask <= hwdata[IRQ_W-1:0];
		end
	end

	// ************************************************************
	// input path
	// ************************************************************
	// a disabled buffer reads low, so a floating pin cannot toggle flags
	assign bufOut = inBufEn && pinIn;

	// two-stage synchronisers for the pin and the slow oscillator
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			pinMeta <= 1'b0;
			pinSync <= 1'b0;
			oscMeta <= 1'b0;
			oscSync <= 1'b0;
			oscLast <= 1'b0;
		end else begin
			pinMeta <= bufOut;
			pinSync <= pinMeta;
			oscMeta <= slowOsc;
			oscSync <= oscMeta;
			oscLast <= oscSync;
		end
	end

	assign slowTick = oscSync && !oscLast;

	debounce_filter u_filter (
		.clk      (clk),
		.rst_n    (rst_n),
		.level    (pinSync),
		.tick     (slowTick),
		.sel      (filterSel),
		.filtered (filteredLevel)
	);

	// edge latches work on the de-bounced level only
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			filtLast <= 1'b0;
		end else begin
			filtLast <= filteredLevel;
		end
	end

	assign riseEvt = filteredLevel && !filtLast;
	assign fallEvt = !filteredLevel && filtLast;
	assign chanAny = chanA || chanB;

	// ************************************************************
	// edge and error flags
	// ************************************************************
	// set beats the clearing write in the same cycle
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			riseFlag <= 1'b0;
		end else if (riseEvt && riseEn && chanAny) begin
			riseFlag <= 1'b1;
		end else if (cfgWrite && !hwdata[BIT_RISE]) begin
			riseFlag <= 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			fallFlag <= 1'b0;
		end else if (fallEvt && fallEn && chanAny) begin
			fallFlag <= 1'b1;
		end else if (cfgWrite && !hwdata[BIT_FALL]) begin
			fallFlag <= 1'b0;
		end
	end

	output_check u_check (
		.clk      (clk),
		.rst_n    (rst_n),
		.enable   (checkEn),
		.driven   (pinOutValue),
		.sampled  (bufOut),
		.mismatch (checkErr)
	);

	// flag is set even with both channels off; only the interrupt waits
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			checkFlag <= 1'b0;
		end else if (checkErr) begin
			checkFlag <= 1'b1;
		end else if (cfgWrite && !hwdata[BIT_CHECK]) begin
			checkFlag <= 1'b0;
		end
	end

	// ************************************************************
	// interrupts
	// ************************************************************
	// sticky status, write one to clear, set wins
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			irqStatus <= '0;
		end else begin
			for (int i = 0; i < IRQ_W; i++) begin
				if (wrPending && wrAddr == OFS_IRQ_STATUS && hwdata[i]) begin
					irqStatus[i] <= 1'b0;
				end
			end
			if (riseEvt && riseEn && chanAny) irqStatus[IRQ_RISE] <= 1'b1;
			if (fallEvt && fallEn && chanAny) irqStatus[IRQ_FALL] <= 1'b1;
			if (checkErr && chanAny) irqStatus[IRQ_CHECK] <= 1'b1;
		end
	end

	assign irq     = |(irqStatus & irqMask);
	assign pinIrqA = chanA && (riseFlag || fallFlag || checkFlag);
	assign pinIrqB = chanB && (riseFlag || fallFlag || checkFlag);

	// ************************************************************
	// checks
	// ************************************************************
	rise_set_a: assert property (@(posedge clk) disable iff (!rst_n)
		(riseEvt && riseEn && chanAny) |=> riseFlag)
		else $error("rise flag not set by enabled rising edge");
	rise_clear_a: assert property (@(posedge clk) disable iff (!rst_n)
		(cfgWrite && !hwdata[BIT_RISE] && !riseEvt) |=> !riseFlag)
		else $error("rise flag survived enable cleared");
	fall_set_a: assert property (@(posedge clk) disable iff (!rst_n)
		(fallEvt && fallEn && chanAny) |=> fallFlag)
		else $error("fall flag not set by enabled falling edge");
	fall_clear_a: assert property (@(posedge clk) disable iff (!rst_n)
		(cfgWrite && !hwdata[BIT_FALL] && !fallEvt) |=> !fallFlag)
		else $error("fall flag survived enable cleared");
	buffer_off_a: assert property (@(posedge clk) disable iff (!rst_n)
		(!inBufEn)[*3] |-> !pinSync)
		else $error("raw level high with buffer disabled");
	check_irq_a: assert property (@(posedge clk) disable iff (!rst_n)
		(checkErr && !chanAny) |=> !$rose(irqStatus[IRQ_CHECK]) && checkFlag)
		else $error("error interrupt raised with channels off");
	check_clear_a: assert property (@(posedge clk) disable iff (!rst_n)
		(cfgWrite && !hwdata[BIT_CHECK] && !checkErr)
		|=> (!checkFlag && !checkEn) ##1 !checkErr[*2])
		else $error("error flag or detection survived disable");
	raw_sync_a: assert property (@(posedge clk) disable iff (!rst_n)
		##2 pinSync == $past(bufOut, 2))
		else $error("raw level not two cycles behind buffer");
	func_reset_a: assert property (@(posedge clk)
		!rst_n |=> functionSelect == FUNC_SEL_RST)
		else $error("function select not reset to zero");
	filter_off_a: assert property (@(posedge clk) disable iff (!rst_n)
		(filterSel == FILT_OFF)[*2] |-> filteredLevel == $past(pinSync))
		else $error("filter off does not pass level through");

	// ************************************************************
	// status, readback and edge checks
	// ************************************************************
	rise_status_a: assert property (@(posedge clk) disable iff (!rst_n)
		(riseEvt && riseEn && chanAny) |=> irqStatus[IRQ_RISE])
		else $error("rise status not set by enabled rising edge");
	fall_status_a: assert property (@(posedge clk) disable iff (!rst_n)
		(fallEvt && fallEn && chanAny) |=> irqStatus[IRQ_FALL])
		else $error("fall status not set by enabled falling edge");
	check_set_a: assert property (@(posedge clk) disable iff (!rst_n)
		checkErr |=> checkFlag)
		else $error("error flag not set by a mismatch");
	check_status_a: assert property (@(posedge clk) disable iff (!rst_n)
		(checkErr && chanAny) |=> irqStatus[IRQ_CHECK])
		else $error("error status not set with a channel enabled");
	status_clear_a: assert property (@(posedge clk) disable iff (!rst_n)
		(wrPending && wrAddr == OFS_IRQ_STATUS && hwdata[IRQ_RISE] && !riseEvt)
		|=> !irqStatus[IRQ_RISE])
		else $error("rise status survived a write of one");
	mask_write_a: assert property (@(posedge clk) disable iff (!rst_n)
		(wrPending && wrAddr == OFS_IRQ_MASK) |=> irqMask == $past(hwdata[IRQ_W-1:0]))
		else $error("mask write did not land");
	fsel_write_a: assert property (@(posedge clk) disable iff (!rst_n)
		(wrPending && wrAddr == OFS_FUNC_SEL) |=> functionSelect == $past(hwdata[7:0]))
		else $error("function select write did not land");
	cfg_reset_a: assert property (@(posedge clk)
		!rst_n |=> pinCfgRead == PIN_CFG_RST)
		else $error("pin config readback not zero after reset");
	edge_once_a: assert property (@(posedge clk) disable iff (!rst_n)
		riseEvt |=> !riseEvt)
		else $error("one rising edge seen twice");
	filter_edge_a: assert property (@(posedge clk) disable iff (!rst_n)
		($rose(filteredLevel) && riseEn && chanAny) |=> riseFlag)
		else $error("de-bounced rise did not set the rise flag");
endmodule : gpio_pin_input

// file: tb/pin_model.sv
/*
 * model of the external pin and the free-running slow oscillator.
 * assumes one system clock; the bench sets the pin behaviour through
 * echo / lag / level right after a rising edge.
 */
`timescale 1ns/1ps
module pin_model #(
	parameter int SLOW_DIV = 8
) (
	input  wire logic       clk,         // system clock
	input  wire logic       echo,        // pin follows driven value
	input  wire logic [2:0] lag,         // clocks of echo delay
	input  wire logic       level,       // pin level when not echoing
	input  wire logic       pinOutValue, // value the port drives
	output logic            pinIn,       // pin as seen by the port
	output logic            slowOsc      // slow oscillator level
);
	logic [7:0] hist;
	logic [8:0] tap;
	int         divCnt;

	initial begin
		hist    = 8'h00;
		divCnt  = 0;
		slowOsc = 1'b0;
	end

	// history of driven values, so a load can lag the driver
	always @(posedge clk) begin
		hist    <= {hist[6:0], pinOutValue};
		divCnt  <= (divCnt + 1) % SLOW_DIV;
		slowOsc <= (divCnt < SLOW_DIV / 2);
	end

	// oscillator shortened: the real rate would make the run far too long
	assign tap   = {hist, pinOutValue};
	assign pinIn = echo ? tap[lag] : level;
endmodule : pin_model

// file: tb/testbench.sv
/*
 * self-checking bench for the gpio pin input block: ahb-lite register
 * tasks and sequences of calls with expected values.
 * assumes the slave answers on hreadyout, which is fed back as hready.
 */
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin checks_done++; if ((got) !== (ex)) begin err_count++; \
	$display("mismatch %s exp %h got %h", nm, ex, got); end end
module testbench;
	import gpio_pin_pkg::*;
	localparam int SLOW_DIV = 8;
	logic        clk, rst_n, hsel, hwrite, hready, hreadyout, hresp;
	logic [15:0] haddr;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	logic [31:0] hwdata, hrdata, rdata;
	logic        pinIn, pinOutValue, slowOsc, filteredLevel;
	logic [7:0]  functionSelect;
	logic        pinIrqA, pinIrqB, irq, echo, level;
	logic [2:0]  lag;
	int          err_count, checks_done;

	assign hready = hreadyout;

	gpio_pin_input dut (.clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hready), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
		.pinIn(pinIn), .pinOutValue(pinOutValue), .slowOsc(slowOsc),
		.filteredLevel(filteredLevel), .functionSelect(functionSelect),
		.pinIrqA(pinIrqA), .pinIrqB(pinIrqB), .irq(irq));

	pin_model #(.SLOW_DIV(SLOW_DIV)) model (.clk(clk), .echo(echo), .lag(lag),
		.level(level), .pinOutValue(pinOutValue), .pinIn(pinIn), .slowOsc(slowOsc));

	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	// ************************************************************
	// bus tasks
	// ************************************************************
	task automatic tally_and_finish();
		$display("checks %0d errors %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask : tally_and_finish

	// bounded wait: a slave that never answers ends the run
	task automatic waitReady();
		int i;
		for (i = 0; i < 50; i++) begin
			@(posedge clk);
			if (hready === 1'b1) break;
		end
		if (i == 50) begin
			err_count++;
			$display("mismatch hready exp 1 got 0");
			tally_and_finish();
		end
	endtask : waitReady

	task automatic busWrite(input logic [15:0] a, input logic [31:0] d);
		haddr  <= a;
		hwrite <= 1'b1;
		htrans <= 2'h2;
		waitReady();
		htrans <= 2'h0;
		hwdata <= d;
		waitReady();
	endtask : busWrite

	task automatic busRead(input logic [15:0] a);
		haddr  <= a;
		hwrite <= 1'b0;
		htrans <= 2'h2;
		waitReady();
		htrans <= 2'h0;
		waitReady();
		rdata = hrdata;
	endtask : busRead

	task automatic chkReg(input string nm, input logic [15:0] a, input logic [31:0] ex);
		busRead(a);
		`CHK(nm, ex, rdata)
	endtask : chkReg

	task automatic idle(input int n);
		repeat (n) @(posedge clk);
	endtask : idle

	// global guard against a hang
	initial begin
		repeat (100000) @(posedge clk);
		err_count++;
		tally_and_finish();
	end

	// ************************************************************
	// main sequence
	// ************************************************************
	initial begin
		int   s;
		int   n;
		logic lvl;
		rst_n = 1'b0; hsel = 1'b1; haddr = 16'h0000; htrans = 2'h0; hwrite = 1'b0;
		hsize = 3'h2; hwdata = 32'h0; pinOutValue = 1'b0; echo = 1'b0; lag = 3'h0;
		level = 1'b0; err_count = 0; checks_done = 0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		`CHK("outputs", 12'h000, {filteredLevel, functionSelect, pinIrqA, pinIrqB, irq})
		`CHK("hresp", 1'b0, hresp)
		chkReg("cfg", OFS_PIN_CFG, 32'h0);
		chkReg("fsel", OFS_FUNC_SEL, 32'h0);
		chkReg("mask", OFS_IRQ_MASK, 32'h0);
		busWrite(OFS_FUNC_SEL, 32'hA5);
		chkReg("fsel", OFS_FUNC_SEL, 32'hA5);
		`CHK("fselport", 8'hA5, functionSelect)
		busWrite(16'hA200, 32'hFF);
		chkReg("unmapped", 16'hA200, 32'h0);
		// buffer off hides a high pin, then on shows it
		level <= 1'b1;
		idle(8);
		chkReg("cfg", OFS_PIN_CFG, 32'h0);
		busWrite(OFS_PIN_CFG, 32'h08);
		idle(8);
		chkReg("cfg", OFS_PIN_CFG, 32'h0B);
		`CHK("filtered", 1'b1, filteredLevel)
		// edge flags, interrupt mask and clearing
		busWrite(OFS_PIN_CFG, 32'h78);
		chkReg("view", OFS_CFG_VIEW, 32'h78);
		level <= 1'b0;
		idle(8);
		chkReg("cfg", OFS_PIN_CFG, 32'h58);
		`CHK("pinirq", 3'b100, {pinIrqA, pinIrqB, irq})
		chkReg("status", OFS_IRQ_STATUS, 32'h2);
		busWrite(OFS_PIN_CFG, 32'hB8);
		idle(1);
		`CHK("pinirqb", 2'b01, {pinIrqA, pinIrqB})
		busWrite(OFS_PIN_CFG, 32'h78);
		busWrite(OFS_IRQ_MASK, 32'h2);
		idle(1);
		`CHK("irq", 1'b1, irq)
		level <= 1'b1;
		idle(8);
		chkReg("cfg", OFS_PIN_CFG, 32'h7B);
		busWrite(OFS_PIN_CFG, 32'h58);
		chkReg("cfg", OFS_PIN_CFG, 32'h5B);
		level <= 1'b0;
		idle(8);
		level <= 1'b1;
		idle(8);
		chkReg("cfg", OFS_PIN_CFG, 32'h5B);
		busWrite(OFS_PIN_CFG, 32'h48);
		chkReg("cfg", OFS_PIN_CFG, 32'h4B);
		`CHK("pinirqa", 1'b0, pinIrqA)
		busWrite(OFS_IRQ_MASK, 32'h0);
		idle(1);
		`CHK("masked", 1'b0, irq)
		busWrite(OFS_IRQ_STATUS, 32'h7);
		chkReg("status", OFS_IRQ_STATUS, 32'h0);
		busWrite(OFS_PIN_CFG, 32'h38);
		level <= 1'b0;
		idle(8);
		chkReg("cfg", OFS_PIN_CFG, 32'h08);
		// output check: a load three clocks late matches, four does not
		echo <= 1'b1;
		lag  <= 3'h3;
		busWrite(OFS_PIN_CFG, 32'h4C);
		pinOutValue <= 1'b1;
		idle(8);
		chkReg("cfg", OFS_PIN_CFG, 32'h4B);
		lag <= 3'h4;
		pinOutValue <= 1'b0;
		idle(8);
		chkReg("cfg", OFS_PIN_CFG, 32'h4C);
		chkReg("status", OFS_IRQ_STATUS, 32'h4);
		busWrite(OFS_PIN_CFG, 32'h48);
		chkReg("cfg", OFS_PIN_CFG, 32'h48);
		pinOutValue <= 1'b1;
		idle(8);
		chkReg("cfg", OFS_PIN_CFG, 32'h4B);
		busWrite(OFS_IRQ_STATUS, 32'h7);
		busWrite(OFS_PIN_CFG, 32'h0C);
		pinOutValue <= 1'b0;
		idle(8);
		chkReg("cfg", OFS_PIN_CFG, 32'h0C);
		chkReg("status", OFS_IRQ_STATUS, 32'h0);
		`CHK("pinirqa", 1'b0, pinIrqA)
		// every filter time; off is checked at once, the timed ones get a short glitch first to test the restart
		echo  <= 1'b0;
		level <= 1'b0;
		lvl = 1'b0;
		busWrite(OFS_PIN_CFG, 32'h08);
		idle(8);
		for (s = 0; s < 4; s++) begin
			busWrite(OFS_PIN_CFG, 32'h08 | s);
			if (s == 0) begin
				lvl = ~lvl;
				level <= lvl;
				idle(6);
				`CHK("nofilter", lvl, filteredLevel)
			end else begin
				n = (s == 1) ? 4 : (s == 2) ? 16 : 64;
				level <= ~lvl;
				idle(2 * SLOW_DIV);
				level <= lvl;
				idle(2 * SLOW_DIV);
				lvl = ~lvl;
				level <= lvl;
				idle((n - 1) * SLOW_DIV);
				`CHK("early", ~lvl, filteredLevel)
				idle(2 * SLOW_DIV + 8);
				`CHK("settled", lvl, filteredLevel)
			end
		end
		tally_and_finish();
	end
endmodule : testbench
